/* src/asr_control.sv */
/*
 * Control and result logic of an 8-bit successive-approximation converter.
 * Assumes one system clock, a register port with read data one cycle late,
 * a comparator decision pin and an internal oscillator pin from outside.
 */
//
// Behaviour
// - Old result stays readable while sampling
// - Clear result to zero after sampling
// - Shift marker one in from top
// - Each decision moves marker, stuffs bit
// - Ninth shift completes, clears go
// - Software go clear aborts, no flag
// - Aborted result keeps decided bits and marker
// - Undecided bits are never recovered
// - Clock select picks divisor or oscillator
// - Channel select routes inputs or reference
// - Enable clear stops and powers down converter
// - Go write starts; completion sets done flag
// - Go ignored while converter disabled
// - Channel change waits for conversion end
// - Sleep clears go, enable; fields to ones
`default_nettype none

module asr_control (
    // Clock and reset
    input  wire logic                   clk_sys_in,
    input  wire logic                   reset_n_in,
    // Register port
    input  wire logic [asr_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [asr_pkg::DATA_W-1:0] wr_data_in,
    input  wire logic                   wr_in,
    input  wire logic                   rd_in,
    output logic [asr_pkg::DATA_W-1:0]  rd_data_out,
    // Analog side
    input  wire logic                   comparator_in,
    input  wire logic                   internal_oscillator_in,
    input  wire logic                   sleep_in,
    output logic [3:0]                  channel_out,
    output logic                        sample_out,
    output logic                        converter_power_out,
    // Interrupt
    output logic                        irq_out
);
    import asr_pkg::*;

    // Registers
    asr_control_type control;
    logic [7:0]      conversion_result;
    logic            conv_done_flag;
    logic            conv_done_mask;
    asr_state_type   state;
    logic [3:0]      tad_count;
    logic [2:0]      bit_index;
    logic [4:0]      div_count;
    logic [1:0]      active_clock_select;
    logic [3:0]      active_channel;
    logic [2:0]      cmp_sync;
    logic            cmp_level;
    logic [2:0]      osc_sync;
    logic            osc_level;
    logic            osc_prev;
    logic [1:0]      osc_edges;

    // Divisor for a clock select code
    function automatic logic [4:0] divisor_of(input logic [1:0] sel);
        case (sel)
            CLKSEL_DIV16: divisor_of = DIV_16;
            CLKSEL_DIV8:  divisor_of = DIV_8;
            default:      divisor_of = DIV_4;
        endcase
    endfunction

    // Bus decode
    wire wr_control = wr_in && (addr_in == OFS_CONTROL);
    wire wr_result  = wr_in && (addr_in == OFS_RESULT);
    wire wr_status  = wr_in && (addr_in == OFS_STATUS);
    wire wr_mask    = wr_in && (addr_in == OFS_MASK);
    wire busy       = (state != ST_IDLE);
    asr_control_type wr_ctrl;
    assign wr_ctrl = asr_control_type'(wr_data_in);

    // Start and stop conditions
    // Enable must already be on: one write that powers the converter and sets go
    // would otherwise start sampling before the converter has settled
    // gate go on enable
    wire start_req  = wr_control && wr_ctrl.go && wr_ctrl.converter_enable
                      && control.converter_enable && !busy;
    wire abort_req  = wr_control && !wr_ctrl.go && busy;
    wire off_req    = wr_control && !wr_ctrl.converter_enable && busy;

    // Conversion clock tick generation
    // divisor or oscillator
    wire use_osc    = (active_clock_select == CLKSEL_OSC);
    wire osc_rise   = osc_level && !osc_prev;
    wire div_tick   = !use_osc && (div_count == divisor_of(active_clock_select) - 5'h01);
    wire osc_tick   = use_osc && osc_rise && (osc_edges == 2'h3);
    wire tad_tick   = busy && (div_tick || osc_tick);

    // Completion on the last shift
    // ninth shift completes
    wire finish     = tad_tick && (state == ST_DECIDE) && (bit_index == 3'h0);
    // Any stop beats a tick on the same edge, so an abort never completes
    // a conversion or raises the done flag behind software's back
    wire stop_now   = sleep_in || abort_req || off_req;

    // Next result word for one decision
    // stuff bit, move marker
    // Lower bits are still zero from the clear, so only two bits change
    logic [7:0] next_result;
    always_comb begin
        next_result = conversion_result;
        next_result[bit_index] = cmp_level;
        if (bit_index != 3'h0) begin
            next_result[bit_index - 3'h1] = 1'b1;
        end
    end

    // Read data mux
    // Unmapped addresses read as zero
    logic [7:0] next_rd_data;
    always_comb begin
        case (addr_in)
            OFS_CONTROL: next_rd_data = control;
            OFS_RESULT:  next_rd_data = conversion_result;
            OFS_STATUS:  next_rd_data = {7'h00, conv_done_flag};
            OFS_MASK:    next_rd_data = {7'h00, conv_done_mask};
            default:     next_rd_data = 8'h00;
        endcase
    end

    // Pin synchronisers: a change counts when the last two stages agree
    // The first stage may go metastable and is only ever shifted onward
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cmp_sync  <= 3'h0;
            cmp_level <= 1'b0;
            osc_sync  <= 3'h0;
            osc_level <= 1'b0;
            osc_prev  <= 1'b0;
        end else begin
            cmp_sync <= {cmp_sync[1:0], comparator_in};
            osc_sync <= {osc_sync[1:0], internal_oscillator_in};
            osc_prev <= osc_level;
            if (cmp_sync[1] == cmp_sync[2]) begin
                cmp_level <= cmp_sync[2];
            end
            if (osc_sync[1] == osc_sync[2]) begin
                osc_level <= osc_sync[2];
            end
        end
    end

    // Conversion clock divider, restarted at each start so that the
    // first period of a conversion is always a whole one
    // one tick per period
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_count <= 5'h00;
        end else if (!busy || div_tick) begin
            div_count <= 5'h00;
        end else begin
            div_count <= div_count + 5'h01;
        end
    end

    // Oscillator edge counter: four synced rising edges make one period.
    // The oscillator runs free, so the first period after a start may be
    // shorter than four full oscillator cycles.
    // oscillator based period
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            osc_edges <= 2'h0;
        end else if (!busy) begin
            osc_edges <= 2'h0;
        end else if (osc_rise) begin
            osc_edges <= osc_edges + 2'h1;
        end
    end

    // Control register: sleep beats hardware clear beats software write
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            control <= asr_control_type'(CONTROL_RESET);
        end else if (sleep_in) begin
            control.conv_clock_select    <= CLKSEL_SLEEP;
            control.input_channel_select <= CHAN_SLEEP;
            control.go                   <= 1'b0;
            control.converter_enable     <= 1'b0;
        end else if (finish) begin
            control.go <= 1'b0;
            if (wr_control) begin
                control.conv_clock_select    <= wr_ctrl.conv_clock_select;
                control.input_channel_select <= wr_ctrl.input_channel_select;
                control.converter_enable     <= wr_ctrl.converter_enable;
            end
        end else if (wr_control) begin
            control.conv_clock_select    <= wr_ctrl.conv_clock_select;
            control.input_channel_select <= wr_ctrl.input_channel_select;
            control.converter_enable     <= wr_ctrl.converter_enable;
            control.go <= busy ? (wr_ctrl.go && wr_ctrl.converter_enable) : start_req;
        end
    end

    // Conversion settings, latched at the start edge only; later writes to
    // the control register wait for the next conversion
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            active_clock_select <= CLKSEL_SLEEP;
            active_channel      <= CHAN_SLEEP;
        end else if (start_req && !stop_now) begin
            active_clock_select <= wr_ctrl.conv_clock_select;
            active_channel      <= wr_ctrl.input_channel_select;
        end
    end

    // Sequencer
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state               <= ST_IDLE;
            tad_count           <= 4'h0;
            bit_index           <= MSB_INDEX;
        end else if (stop_now) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        state               <= ST_SAMPLE;
                        tad_count           <= 4'h0;
                    end
                end
                ST_SAMPLE: begin
                    if (tad_tick) begin
                        tad_count <= tad_count + 4'h1;
                        if (tad_count == SAMPLE_TAD - 4'h1) begin
                            state <= ST_CLEAR;
                        end
                    end
                end
                ST_CLEAR: begin
                    if (tad_tick) begin
                        state <= ST_MARK;
                    end
                end
                ST_MARK: begin
                    if (tad_tick) begin
                        state     <= ST_DECIDE;
                        bit_index <= MSB_INDEX;
                    end
                end
                ST_DECIDE: begin
                    if (tad_tick) begin
                        bit_index <= bit_index - 3'h1;
                        if (bit_index == 3'h0) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Result register
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            conversion_result <= RESULT_RESET;
        end else if (!busy) begin
            // partial result kept
            // Software may only overwrite it while idle, so a running
            // conversion is never corrupted by a stray write
            if (wr_result) begin
                conversion_result <= wr_data_in;
            end
        end else if (tad_tick && !stop_now) begin
            if (state == ST_CLEAR) begin
                conversion_result <= RESULT_RESET;
            end else if (state == ST_MARK) begin
                conversion_result <= RESULT_MARKER;
            end else if (state == ST_DECIDE) begin
                conversion_result <= next_result;
            end
        end
    end

    // Done flag: set wins over the write-one clear
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            conv_done_flag <= 1'b0;
            conv_done_mask <= 1'b0;
        end else begin
            if (finish && !stop_now) begin
                conv_done_flag <= 1'b1;
            end else if (wr_status && wr_data_in[POS_DONE_FLAG]) begin
                conv_done_flag <= 1'b0;
            end
            if (wr_mask) begin
                conv_done_mask <= wr_data_in[POS_DONE_FLAG];
            end
        end
    end

    // Bus side outputs: read data stand one cycle for each cycle the read strobe is held, then drop to zero
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= 8'h00;
            irq_out     <= 1'b0;
        end else begin
            rd_data_out <= rd_in ? next_rd_data : 8'h00;
            // level interrupt from flag and mask
            irq_out     <= conv_done_flag && conv_done_mask;
        end
    end

    // Analog side outputs, registered so the converter sees clean levels
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            channel_out         <= CHAN_SLEEP;
            sample_out          <= 1'b0;
            converter_power_out <= 1'b0;
        end else begin
            channel_out         <= busy ? active_channel : control.input_channel_select;
            sample_out          <= (state == ST_SAMPLE) && !stop_now;
            converter_power_out <= control.converter_enable && !sleep_in;
        end
    end

endmodule

`default_nettype wire

/* pkg/asr_pkg.sv */
/*
 * Shared constants and types for the successive-approximation result control.
 * Assumes a single system clock domain.
 */
`default_nettype none

package asr_pkg;

    // Register bus geometry
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [2:0] OFS_CONTROL = 3'h0;
    localparam logic [2:0] OFS_RESULT  = 3'h1;
    localparam logic [2:0] OFS_STATUS  = 3'h2;
    localparam logic [2:0] OFS_MASK    = 3'h3;

    // Field positions inside the control register, and of the done bit in the status and mask registers
    localparam int unsigned POS_ENABLE = 0;
    localparam int unsigned POS_GO     = 1;
    localparam int unsigned POS_DONE_FLAG = 0;

    // Values after reset and after sleep, and the result marker
    localparam logic [7:0] CONTROL_RESET = 8'hFC;
    localparam logic [1:0] CLKSEL_SLEEP  = 2'h3;
    localparam logic [3:0] CHAN_SLEEP    = 4'hF;
    localparam logic [7:0] RESULT_RESET  = 8'h00;
    localparam logic [7:0] RESULT_MARKER = 8'h80;

    // Clock select codes and divisors
    localparam logic [1:0] CLKSEL_DIV16 = 2'h0;
    localparam logic [1:0] CLKSEL_DIV8  = 2'h1;
    localparam logic [1:0] CLKSEL_DIV4  = 2'h2;
    localparam logic [1:0] CLKSEL_OSC   = 2'h3;
    localparam logic [4:0] DIV_16       = 5'h10;
    localparam logic [4:0] DIV_8        = 5'h08;
    localparam logic [4:0] DIV_4        = 5'h04;

    // Conversion timing in conversion clock periods
    localparam logic [3:0] SAMPLE_TAD    = 4'h3;
    localparam logic [2:0] MSB_INDEX     = 3'h7;

    // Channel codes
    localparam logic [3:0] CHAN_REFERENCE = 4'hF;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] conv_clock_select;
        logic [3:0] input_channel_select;
        logic       go;
        logic       converter_enable;
    } asr_control_type;

    // Conversion sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CLEAR,
        ST_MARK,
        ST_DECIDE
    } asr_state_type;

endpackage

`default_nettype wire

/* testbench/asr_control_sva.sv */
/* Port assertions for the converter control block.
   Assumes it is bound to asr_control and one clock domain. */
`default_nettype none
module asr_control_sva
    import asr_pkg::*;
(
    // Clock, reset and register port
    input wire logic       clk_sys_in,
    input wire logic       reset_n_in,
    input wire logic [2:0] addr_in,
    input wire logic       wr_in,
    // Converter side
    input wire logic       sleep_in,
    input wire logic [3:0] channel_out,
    input wire logic       sample_out,
    input wire logic       converter_power_out,
    input wire logic       irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    // Sleep held long enough to land in the control register
    sequence s_sleep_held;
        sleep_in [*3];
    endsequence
    // A control write two edges back: the start edge, then the registered sample flag
    sequence s_start_write;
        $past(wr_in, 2) && $past(addr_in, 2) == OFS_CONTROL;
    endsequence
    a_sample_cause: assert property ($rose(sample_out) |-> s_start_write)
        else $error("sampling began without a control write");
    a_start_powered: assert property ($rose(sample_out) |-> converter_power_out)
        else $error("sampling began while powered down");
    a_sample_min: assert property ($rose(sample_out) |-> sample_out [*8])
        else $error("sampling phase too short");
    a_chan_hold: assert property (sample_out && $past(sample_out) |-> $stable(channel_out))
        else $error("channel moved while sampling");
    a_sleep_power: assert property (s_sleep_held |=> !converter_power_out)
        else $error("converter powered in sleep");
    a_sleep_sample: assert property (s_sleep_held |=> !sample_out)
        else $error("sampling in sleep");
    a_off_idle: assert property (!converter_power_out && $past(!converter_power_out) |-> !sample_out)
        else $error("sampling while switched off");
    a_irq_quiet: assert property ($rose(irq_out) && !$past(wr_in, 2) |-> !sample_out)
        else $error("interrupt raised during sampling");
endmodule
bind asr_control asr_control_sva u_asr_control_sva (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .addr_in(addr_in), .wr_in(wr_in), .sleep_in(sleep_in), .channel_out(channel_out), .sample_out(sample_out),
    .converter_power_out(converter_power_out), .irq_out(irq_out));
`default_nettype wire

/* testbench/tb_asr_control.sv */
/* Self-checking bench for the converter control block.
   Assumes the register port answers one cycle after a read strobe. */
`default_nettype none
module tb_asr_control;
    timeunit 1ns;
    timeprecision 1ps;
    import asr_pkg::*;
    logic       clk_sys_in, reset_n_in, wr_in, rd_in, comparator_in, internal_oscillator_in, sleep_in;
    logic [2:0] addr_in;
    logic [7:0] wr_data_in, rd_data_out, d, prev;
    logic [3:0] channel_out, ch;
    logic [1:0] osc_cnt;
    logic       sample_out, converter_power_out, irq_out;
    int         errors, compares, run, last_len;

    asr_control u_asr_control (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
        .comparator_in(comparator_in), .internal_oscillator_in(internal_oscillator_in), .sleep_in(sleep_in),
        .channel_out(channel_out), .sample_out(sample_out), .converter_power_out(converter_power_out),
        .irq_out(irq_out));

    // 25 MHz clock
    always #20 clk_sys_in = ~clk_sys_in;
    // Slow oscillator, four clocks a period, and sampling length meter
    always @(posedge clk_sys_in) begin
        osc_cnt <= osc_cnt + 2'h1;
        internal_oscillator_in <= osc_cnt[1];
        if (sample_out) begin
            run <= run + 1;
        end else if (run != 0) begin
            last_len <= run;
            run <= 0;
        end
    end

    task automatic conclude();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Trailing delay lets the write edge's updates land before any look
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys_in);
        addr_in <= a;
        wr_data_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 v = rd_data_out;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string n);
        rd(a, d);
        check(n, d, exp);
    endtask
    // Bounded waits: a spent bound ends the run as a failure
    task automatic wait_done();
        for (int i = 0; i < 400; i++) begin
            rd(OFS_CONTROL, d);
            if (!d[POS_GO]) return;
        end
        errors++;
        conclude();
    endtask
    task automatic wait_sample(input logic lvl);
        for (int i = 0; i < 600; i++) begin
            @(posedge clk_sys_in);
            #1;
            if (sample_out === lvl) return;
        end
        errors++;
        conclude();
    endtask

    initial begin
        {clk_sys_in, reset_n_in, wr_in, rd_in, comparator_in, internal_oscillator_in, sleep_in} = 7'h00;
        {addr_in, wr_data_in, osc_cnt, prev} = 21'h0;
        {errors, compares, run, last_len} = '0;
        repeat (6) @(posedge clk_sys_in);
        check("reset chan", {4'h0, channel_out}, 8'h0F);
        reset_n_in <= 1'b1;
        rchk(OFS_CONTROL, CONTROL_RESET, "reset ctrl");
        @(posedge clk_sys_in);
        #1 check("read idle", rd_data_out, 8'h00);
        rchk(3'h5, 8'h00, "unmapped");
        wr(OFS_CONTROL, 8'h02);
        rchk(OFS_CONTROL, 8'h00, "go while off");
        wr(OFS_CONTROL, 8'h03);
        rchk(OFS_CONTROL, 8'h01, "go with enable");
        // Every clock select; routes include the fixed reference
        for (int s = 0; s < 4; s++) begin
            ch = (s == 3) ? 4'hF : 4'(s * 3);
            @(posedge clk_sys_in);
            comparator_in <= s[0];
            wr(OFS_MASK, {7'h0, s != 1});
            wr(OFS_CONTROL, {2'(s), ch, 2'b01});
            wr(OFS_CONTROL, {2'(s), ch, 2'b11});
            wait_sample(1'b1);
            rchk(OFS_RESULT, prev, "held result");
            wr(OFS_CONTROL, {2'(s), 4'h7, 2'b11});
            check("route", {4'h0, channel_out}, {4'h0, ch});
            wait_done();
            prev = {8{s[0]}};
            if (s < 3) check("sample len", 8'(last_len), 8'(48 >> s));
            else check("osc len", {7'h0, last_len > 44 && last_len < 49}, 8'h01);
            rchk(OFS_RESULT, prev, "result");
            rchk(OFS_STATUS, 8'h01, "flag");
            check("irq", {7'h0, irq_out}, {7'h0, s != 1});
            wr(OFS_STATUS, 8'h01);
            rchk(OFS_STATUS, 8'h00, "flag clear");
        end
        // Abort after two decisions of zero
        @(posedge clk_sys_in);
        comparator_in <= 1'b0;
        wr(OFS_CONTROL, 8'h83);
        for (int i = 0; i < 100 && d !== 8'h20; i++) rd(OFS_RESULT, d);
        if (d !== 8'h20) begin
            errors++;
            conclude();
        end
        wr(OFS_CONTROL, 8'h81);
        rd(OFS_RESULT, d);
        check("partial", {7'h0, $onehot(d) && d <= 8'h20}, 8'h01);
        repeat (60) @(posedge clk_sys_in);
        rchk(OFS_RESULT, d, "lost bits");
        rchk(OFS_STATUS, 8'h00, "no flag");
        rchk(OFS_CONTROL, 8'h81, "halted");
        // Sleep in mid conversion, past the sampling phase
        wr(OFS_CONTROL, 8'h83);
        wait_sample(1'b1);
        wait_sample(1'b0);
        check("power on", {7'h0, converter_power_out}, 8'h01);
        @(posedge clk_sys_in);
        sleep_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        #1;
        check("power off", {7'h0, converter_power_out}, 8'h00);
        rchk(OFS_CONTROL, CONTROL_RESET, "sleep ctrl");
        @(posedge clk_sys_in);
        sleep_in <= 1'b0;
        wr(3'h6, 8'h03);
        rchk(OFS_CONTROL, CONTROL_RESET, "unmapped wr");
        conclude();
    end
endmodule
`default_nettype wire
